//--- verilog/tap_pkg.sv
// constants for the test access port and debug mailbox block
// assumes one 25 MHz core clock; the test clock is sampled as data
package tap_pkg;

  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam int          IR_WIDTH        = 4;
  localparam logic [3:0]  OP_EXTEST       = 4'h0;
  localparam logic [3:0]  OP_IDCODE       = 4'h1;
  localparam logic [3:0]  OP_SAMPLE       = 4'h2;
  localparam logic [3:0]  OP_DBG_ZERO     = 4'h8;
  localparam logic [3:0]  OP_DBG_ONE      = 4'h9;
  localparam logic [3:0]  OP_DBG_TWO      = 4'ha;
  localparam logic [3:0]  OP_DBG_THREE    = 4'hb;
  localparam logic [3:0]  OP_DEV_RESET    = 4'hc;
  localparam logic [3:0]  OP_BYPASS       = 4'hf;
  localparam logic [3:0]  IR_CAPTURE      = 4'h1;

  // ----------------------------------------
  // identification word (values arbitrary)
  // ----------------------------------------
  localparam logic [3:0]  ID_VERSION      = 4'h0;
  localparam logic [15:0] ID_PART         = 16'h1234;
  localparam logic [10:0] ID_MAKER        = 11'h055;

  // ----------------------------------------
  // debug register layout
  // ----------------------------------------
  localparam int          DBG_WIDTH       = 16;
  localparam int          DBG_MBOX_LSB    = 0;
  localparam int          DBG_DIRTY_BIT   = 8;
  localparam int          DBG_ACC_BIT     = 9;
  localparam int          DBG_CLR_BIT     = 10;
  localparam int          DBG_BRK_CFG_LSB = 11;
  localparam int          DBG_STEP_BIT    = 14;
  localparam int          DBG_FLOW_BIT    = 15;
  localparam int          CPU_WIDTH       = 16;
  localparam int          BP_WIDTH        = 16;
  localparam int          BP_SEL_WIDTH    = 2;
  localparam int          BPCFG_WIDTH     = 3;
  localparam logic [2:0]  BP_4PROG        = 3'h0;
  localparam logic [2:0]  BP_3P1D         = 3'h1;
  localparam logic [2:0]  BP_2P2D         = 3'h2;
  localparam logic [2:0]  BP_2P_PRANGE    = 3'h3;
  localparam logic [2:0]  BP_2P_DRANGE    = 3'h4;
  localparam int          TLR_ONES        = 5;

  typedef enum logic [3:0] {
    TLR, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
  } tap_state_e;

endpackage

//--- verilog/tap_debug_port.sv
// test access port, boundary scan, device reset and debug mailbox
// assumes tck/tms/tdi from the pins, cpu bus strobes on core_clk
//
// Notes on behaviour
// - five tms-high test clocks always reach test-logic-reset
// - break unit: flow change, single step, two program, two combined
// - four break points limited to five legal program/data mixes
// - debugger feeds cpu instructions via the cpu scan chain
// - debug updates work only with both fuses set and no lock bit; debug register captures are not gated
// - cpu mailbox write stores byte and sets dirty flag
// - cpu mailbox read: seven low data bits, dirty flag on top
// - shared address reaches mailbox only with fuse and access enable
// - port enabled only with port fuse and disable bit clear
// - debug fuse programming refused while a lock bit is set, until a chip erase is seen
// - identification is the instruction after power up
// - extest, idcode, sample, bypass and device reset supported
// - entering reset makes all port pins high impedance at once
// - reset by pin low or device reset instruction with bit set
// - boundary latches drive pins once extest is loaded
// - sample captures pin levels without disturbing operation
// - bypass gives a one-bit path from tdi to tdo
// - instruction register is four bits wide
// - opcodes: extest 0, idcode 1, sample 2, reset c, bypass f
// - every shift register shifts least significant bit first
// - reset register output unlatched, reset held while it is one under the device reset instruction
`timescale 1ns/1ps

module tap_debug_port
  import tap_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  output logic                              tdo,
  output logic                              tdo_oe,
  input  wire logic                         reset_pin_n,
  input  wire logic                         port_enable_fuse,
  input  wire logic                         debug_enable_fuse,
  input  wire logic                         lock_bit_one,
  input  wire logic                         lock_bit_two,
  input  wire logic                         port_disable_bit,
  input  wire logic [PINS-1:0]              pin_in,
  input  wire logic [PINS-1:0]              core_out,
  input  wire logic [PINS-1:0]              core_oe,
  output logic      [PINS-1:0]              pin_out,
  output logic      [PINS-1:0]              pin_oe,
  output logic                              device_reset,
  input  wire logic                         mbox_wr,
  input  wire logic                         mbox_rd_sel,
  input  wire logic [7:0]                   mbox_wdata,
  input  wire logic [7:0]                   io_rdata,
  output logic      [7:0]                   mbox_rdata,
  output logic                              io_sel,
  output logic      [tap_pkg::CPU_WIDTH-1:0] cpu_instr,
  output logic                              cpu_instr_valid,
  input  wire logic [tap_pkg::CPU_WIDTH-1:0] cpu_result,
  output logic      [tap_pkg::BPCFG_WIDTH-1:0] break_cfg,
  output logic                              break_step,
  output logic                              break_flow,
  output logic      [tap_pkg::BP_SEL_WIDTH-1:0] bp_sel,
  output logic      [tap_pkg::BP_WIDTH-1:0] bp_addr,
  output logic                              bp_wr,
  output logic                              debug_fuse_prog_ok,
  input  wire logic                         chip_erase_done
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    // pin inputs pass two flops before any logic reads them
    logic [1:0]           tck_s, tms_s, tdi_s;
    logic                 tck_d;
    logic [1:0]           rpin_s;
    logic [PINS-1:0]      pin_m, pin_q;
    tap_state_e           st;
    logic [3:0]           ir_sh;
    logic [3:0]           ir;
    logic [31:0]          dr_sh;
    logic [PINS*2-1:0]    bs_latch;
    logic                 rst_reg;
    logic [7:0]           mbox;
    logic                 dirty;
    logic                 mbox_access;
    logic                 erased;
    logic [BPCFG_WIDTH-1:0] brk_cfg;
    logic                 brk_step, brk_flow;
    logic                 tdo, tdo_oe;
    logic [PINS-1:0]      pin_out, pin_oe;
    logic                 dev_rst;
    logic [7:0]           mbox_rdata;
    logic                 io_sel;
    logic [CPU_WIDTH-1:0] cpu_instr;
    logic                 cpu_valid;
    logic [BP_SEL_WIDTH-1:0] bp_sel;
    logic [BP_WIDTH-1:0]  bp_addr;
    logic                 bp_wr;
    logic                 fuse_ok;
  } tap_s;

  tap_s r;
  tap_s next_r;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic tap_state_e tap_next(input tap_state_e s,
                                          input logic m);
    unique case (s)
      TLR:    tap_next = m ? TLR    : IDLE;
      IDLE:   tap_next = m ? SEL_DR : IDLE;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR:  tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UP_DR  : PA_DR;
      PA_DR:  tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UP_DR  : SH_DR;
      UP_DR:  tap_next = m ? SEL_DR : IDLE;
      SEL_IR: tap_next = m ? TLR    : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR:  tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UP_IR  : PA_IR;
      PA_IR:  tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UP_IR  : SH_IR;
      UP_IR:  tap_next = m ? SEL_DR : IDLE;
    endcase
  endfunction

  // length of the selected data path
  function automatic int dr_len(input logic [3:0] op);
    unique case (op)
      OP_IDCODE:                  dr_len = 32;
      OP_EXTEST, OP_SAMPLE:       dr_len = PINS * 3;
      OP_DEV_RESET, OP_BYPASS:    dr_len = 1;
      OP_DBG_ZERO, OP_DBG_ONE,
      OP_DBG_TWO:                 dr_len = DBG_WIDTH;
      OP_DBG_THREE:               dr_len = BP_SEL_WIDTH + BP_WIDTH;
      default:                    dr_len = 1;
    endcase
  endfunction

  function automatic logic is_debug_op(input logic [3:0] op);
    is_debug_op = (op[3:2] == 2'b10);
  endfunction

  function automatic logic legal_mix(input logic [BPCFG_WIDTH-1:0] c);
    legal_mix = (c <= BP_2P_DRANGE);
  endfunction

  logic port_on;
  logic dbg_on;
  logic tck_rise;
  logic [31:0] id_word;
  logic [DBG_WIDTH-1:0] dbg_word;
  int len;

  // ----------------------------------------
  // port and debug gating
  // ----------------------------------------
  assign port_on  = port_enable_fuse && !port_disable_bit;
  assign dbg_on   = port_on && debug_enable_fuse
                    && !lock_bit_one && !lock_bit_two;
  assign tck_rise = r.tck_s[1] && !r.tck_d;
  assign id_word  = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign len      = dr_len(r.ir);

  // mailbox owns the shared address only with fuse and access enable
  function automatic logic io_sel_now();
    io_sel_now = debug_enable_fuse && r.mbox_access && dbg_on;
  endfunction

  // ----------------------------------------
  // debug word view
  // ----------------------------------------
  always_comb begin
    dbg_word = '0;
    dbg_word[DBG_MBOX_LSB +: 8]                 = r.mbox;
    dbg_word[DBG_DIRTY_BIT]                     = r.dirty;
    dbg_word[DBG_ACC_BIT]                       = r.mbox_access;
    dbg_word[DBG_BRK_CFG_LSB +: BPCFG_WIDTH]    = r.brk_cfg;
    dbg_word[DBG_STEP_BIT]                      = r.brk_step;
    dbg_word[DBG_FLOW_BIT]                      = r.brk_flow;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.tck_s = {r.tck_s[0], tck};
    next_r.tms_s = {r.tms_s[0], tms};
    next_r.tdi_s = {r.tdi_s[0], tdi};
    next_r.tck_d = r.tck_s[1];
    next_r.rpin_s = {r.rpin_s[0], reset_pin_n};
    next_r.pin_m = pin_in;
    next_r.pin_q = r.pin_m;
    next_r.cpu_valid = 1'b0;
    next_r.bp_wr = 1'b0;
    if (chip_erase_done)
      next_r.erased = 1'b1;
    // debug fuse programming is allowed or refused by this gate
    next_r.fuse_ok = !(lock_bit_one || lock_bit_two) || r.erased;

    if (!port_on) begin
      next_r.st = TLR;
      next_r.ir = OP_IDCODE;
      next_r.rst_reg = 1'b0;
    end else if (tck_rise) begin
      next_r.st = tap_next(r.st, r.tms_s[1]);
      unique case (r.st)
        TLR: begin
          next_r.ir = OP_IDCODE;
          next_r.rst_reg = 1'b0;
        end
        CAP_IR: next_r.ir_sh = IR_CAPTURE;
        SH_IR:  next_r.ir_sh = {r.tdi_s[1], r.ir_sh[3:1]};
        UP_IR:  next_r.ir = r.ir_sh;
        CAP_DR: begin
          next_r.dr_sh = '0;
          unique case (r.ir)
            OP_IDCODE: next_r.dr_sh = id_word;
            OP_EXTEST, OP_SAMPLE:
              next_r.dr_sh[PINS*3-1:0] = {core_oe, core_out, r.pin_q};
            OP_DEV_RESET: next_r.dr_sh[0] = r.rst_reg;
            OP_DBG_ZERO, OP_DBG_TWO:
              next_r.dr_sh[DBG_WIDTH-1:0] = dbg_word;
            OP_DBG_ONE: next_r.dr_sh[CPU_WIDTH-1:0] = cpu_result;
            default: ;
          endcase
        end
        SH_DR: begin
          next_r.dr_sh = r.dr_sh >> 1;
          next_r.dr_sh[len-1] = r.tdi_s[1];
          if (r.ir == OP_DEV_RESET)
            next_r.rst_reg = r.tdi_s[1];
        end
        UP_DR: begin
          unique case (r.ir)
            OP_EXTEST, OP_SAMPLE:
              next_r.bs_latch = r.dr_sh[PINS*3-1:PINS];
            OP_DBG_ZERO: if (dbg_on) begin
              if (r.dr_sh[DBG_CLR_BIT])
                next_r.dirty = 1'b0;
              next_r.mbox_access = r.dr_sh[DBG_ACC_BIT];
              // an illegal mix keeps the previous mix; step and flow bits still load
              if (legal_mix(r.dr_sh[DBG_BRK_CFG_LSB +: BPCFG_WIDTH]))
                next_r.brk_cfg = r.dr_sh[DBG_BRK_CFG_LSB +: BPCFG_WIDTH];
              next_r.brk_step = r.dr_sh[DBG_STEP_BIT];
              next_r.brk_flow = r.dr_sh[DBG_FLOW_BIT];
            end
            OP_DBG_ONE: if (dbg_on) begin
              next_r.cpu_instr = r.dr_sh[CPU_WIDTH-1:0];
              next_r.cpu_valid = 1'b1;
            end
            OP_DBG_THREE: if (dbg_on) begin
              next_r.bp_addr = r.dr_sh[BP_WIDTH-1:0];
              next_r.bp_sel  = r.dr_sh[BP_WIDTH +: BP_SEL_WIDTH];
              next_r.bp_wr   = 1'b1;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // ----------------------------------------
    // mailbox
    // ----------------------------------------
    // set wins over a same-cycle clear
    if (mbox_wr && io_sel_now()) begin
      next_r.mbox  = mbox_wdata;
      next_r.dirty = 1'b1;
    end

    next_r.io_sel = io_sel_now();
    next_r.mbox_rdata = io_sel_now() ? {r.dirty, r.mbox[6:0]}
                                     : io_rdata;
    // ----------------------------------------
    // reset source and pin drive
    // ----------------------------------------
    // reset pin passes two flops and the dev_rst register, costing three cycles of lag
    next_r.dev_rst = !r.rpin_s[1]
                     || (r.ir == OP_DEV_RESET && r.rst_reg);
    next_r.tdo_oe = (r.st == SH_DR || r.st == SH_IR);
    // tdo lags the shift by one cycle, well inside a test clock half
    next_r.tdo = (r.st == SH_IR) ? r.ir_sh[0] : r.dr_sh[0];
    if (next_r.dev_rst) begin
      next_r.pin_oe = '0;
      next_r.pin_out = '0;
    end else if (r.ir == OP_EXTEST) begin
      next_r.pin_out = r.bs_latch[PINS-1:0];
      next_r.pin_oe  = r.bs_latch[PINS*2-1:PINS];
    end else begin
      next_r.pin_out = core_out;
      next_r.pin_oe  = core_oe;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= TLR;
      r.ir <= OP_IDCODE;
      r.rpin_s <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // output ports
  // ----------------------------------------
  assign tdo                = r.tdo;
  assign tdo_oe             = r.tdo_oe;
  assign pin_out            = r.pin_out;
  assign pin_oe             = r.pin_oe;
  assign device_reset       = r.dev_rst;
  assign mbox_rdata         = r.mbox_rdata;
  assign io_sel             = r.io_sel;
  assign cpu_instr          = r.cpu_instr;
  assign cpu_instr_valid    = r.cpu_valid;
  assign break_cfg          = r.brk_cfg;
  assign break_step         = r.brk_step;
  assign break_flow         = r.brk_flow;
  assign bp_sel             = r.bp_sel;
  assign bp_addr            = r.bp_addr;
  assign bp_wr              = r.bp_wr;
  assign debug_fuse_prog_ok = r.fuse_ok;

endmodule

//--- testbench/tap_debug_port_sva.sv
// assertions on the ports of the test access port block
// assumes binding into tap_debug_port; sees its ports only
`timescale 1ns/1ps

module tap_debug_port_sva #(
  parameter int PINS = 8
) (
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            tck,
  input wire logic            tms,
  input wire logic            tdo_oe,
  input wire logic            reset_pin_n,
  input wire logic            port_enable_fuse,
  input wire logic            debug_enable_fuse,
  input wire logic            lock_bit_one,
  input wire logic            lock_bit_two,
  input wire logic            port_disable_bit,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic            device_reset,
  input wire logic            mbox_wr,
  input wire logic [7:0]      mbox_wdata,
  input wire logic [7:0]      io_rdata,
  input wire logic [7:0]      mbox_rdata,
  input wire logic            io_sel,
  input wire logic            cpu_instr_valid,
  input wire logic            bp_wr,
  input wire logic            debug_fuse_prog_ok,
  input wire logic            chip_erase_done
);
  // ----
  // helper state: tms-high run at raw tck rises, erase seen, last byte
  // ----
  typedef struct packed {
    logic       tck_q;
    logic [2:0] ones;
    logic       erased;
    logic [7:0] wd;
  } watch_s;
  watch_s st;
  watch_s next_st;
  always_comb begin
    next_st = st;
    next_st.tck_q = tck;
    if (tck && !st.tck_q && !tms) next_st.ones = 3'd0;
    if (tck && !st.tck_q && tms && st.ones != 3'd5)
      next_st.ones = st.ones + 3'd1;
    if (chip_erase_done) next_st.erased = 1'b1;
    if (mbox_wr) next_st.wd = mbox_wdata;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // checks; sync lag of the test pins is about four core cycles
  // ----
  a_tlr_after_ones: assert property (
    st.ones == 3'd5 |-> ##6 !tdo_oe) else $error("tdo driven after reset run");
  a_port_off_quiet: assert property (
    (!port_enable_fuse || port_disable_bit)[*3] |-> !tdo_oe)
    else $error("disabled port drives tdo");
  a_reset_pins_hiz: assert property (
    device_reset && $past(device_reset) |-> pin_oe == '0)
    else $error("pins driven in reset");
  a_pin_reset_src: assert property (
    !reset_pin_n |-> ##3 device_reset) else $error("reset pin ignored");
  a_debug_gated: assert property (
    cpu_instr_valid || bp_wr |-> debug_enable_fuse && !lock_bit_one
    && !lock_bit_two) else $error("debug update while locked");
  a_instr_pulse: assert property (
    cpu_instr_valid |=> !cpu_instr_valid) else $error("instr valid long");
  a_bp_wr_pulse: assert property (
    bp_wr |=> !bp_wr) else $error("break write long");
  a_mbox_dirty_read: assert property (
    mbox_wr && io_sel |-> ##2 mbox_rdata == {1'b1, st.wd[6:0]})
    else $error("mailbox read wrong after write");
  a_io_passthru: assert property (
    (!io_sel && $stable(io_rdata))[*3] |-> mbox_rdata == io_rdata)
    else $error("ordinary location not read");
  a_sel_needs_fuse: assert property (
    !debug_enable_fuse[*2] |-> !io_sel) else $error("mailbox without fuse");
  a_fuse_lock_hold: assert property (
    ((lock_bit_one || lock_bit_two) && !st.erased)[*2]
    |-> !debug_fuse_prog_ok) else $error("fuse programmable while locked");
endmodule

bind tap_debug_port tap_debug_port_sva #(.PINS(PINS)) i_sva (
  .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdo_oe(tdo_oe), .reset_pin_n(reset_pin_n),
  .port_enable_fuse(port_enable_fuse),
  .debug_enable_fuse(debug_enable_fuse),
  .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
  .port_disable_bit(port_disable_bit), .pin_oe(pin_oe),
  .device_reset(device_reset), .mbox_wr(mbox_wr),
  .mbox_wdata(mbox_wdata), .io_rdata(io_rdata),
  .mbox_rdata(mbox_rdata), .io_sel(io_sel),
  .cpu_instr_valid(cpu_instr_valid), .bp_wr(bp_wr),
  .debug_fuse_prog_ok(debug_fuse_prog_ok),
  .chip_erase_done(chip_erase_done)
);

//--- testbench/jtag_host_model.sv
// test controller model driving tck, tms and tdi and reading tdo
// assumes the bench core clock; tck stands low between frames
`timescale 1ns/1ps

module jtag_host_model (
  input  wire logic core_clk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck = 1'b0,
  output logic      tms = 1'b1,
  output logic      tdi = 1'b1
);
  logic q;
  // one tck: 4 core cycles low, 4 high; tdo taken just before the rise
  task automatic step(input logic m, input logic d);
    @(posedge core_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    // a released tdo floats to its pull-up level
    q = tdo_oe ? tdo : 1'b1;
    tck <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  // park: tck low, tdi back to its pull-up level
  task automatic idle();
    @(posedge core_clk);
    tck <= 1'b0;
    tdi <= 1'b1;
    // registered results of an update settle before callers look
    @(posedge core_clk);
  endtask
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) step(m[i], 1'b1);
    idle();
  endtask
  // whole chain treated as one shift register, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] o);
    o = '0;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    if (ir) step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i]);
      o[i] = q;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    idle();
  endtask
endmodule

//--- testbench/test_tap_debug_port.sv
// self-checking bench for the test access port block
// assumes the host model and the bound checker
`timescale 1ns/1ps

module test_tap_debug_port;
  import tap_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe, device_reset, io_sel;
  logic        reset_pin_n = 1'b1, port_enable_fuse = 1'b1;
  logic        debug_enable_fuse = 1'b1, port_disable_bit = 1'b0;
  logic        lock_bit_one = 1'b0, lock_bit_two = 1'b0;
  logic        mbox_wr = 1'b0, mbox_rd_sel = 1'b0, chip_erase_done = 1'b0;
  logic        cpu_instr_valid, break_step, break_flow, bp_wr;
  logic        debug_fuse_prog_ok;
  logic [7:0]  pin_in = 8'ha5, core_out = 8'h3c, core_oe = 8'h0f;
  logic [7:0]  pin_out, pin_oe, mbox_rdata;
  logic [7:0]  mbox_wdata = 8'h00, io_rdata = 8'h66;
  logic [15:0] cpu_instr, bp_addr, cpu_result = 16'hbeef;
  logic [2:0]  break_cfg;
  logic [1:0]  bp_sel;
  logic [31:0] r, id;
  logic [2:0]  mix [5];
  int          mismatches = 0, tests_run = 0, cycles = 0;

  tap_debug_port #(.PINS(8)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .reset_pin_n(reset_pin_n),
    .port_enable_fuse(port_enable_fuse),
    .debug_enable_fuse(debug_enable_fuse),
    .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
    .port_disable_bit(port_disable_bit), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .device_reset(device_reset), .mbox_wr(mbox_wr),
    .mbox_rd_sel(mbox_rd_sel), .mbox_wdata(mbox_wdata),
    .io_rdata(io_rdata), .mbox_rdata(mbox_rdata), .io_sel(io_sel),
    .cpu_instr(cpu_instr), .cpu_instr_valid(cpu_instr_valid),
    .cpu_result(cpu_result), .break_cfg(break_cfg),
    .break_step(break_step), .break_flow(break_flow), .bp_sel(bp_sel),
    .bp_addr(bp_addr), .bp_wr(bp_wr),
    .debug_fuse_prog_ok(debug_fuse_prog_ok),
    .chip_erase_done(chip_erase_done)
  );
  jtag_host_model i_host (
    .core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
    .tms(tms), .tdi(tdi)
  );

  always #20 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic ir(input logic [3:0] op);
    i_host.scan(1'b1, 4, {28'h0, op}, r);
  endtask
  task automatic dr(input int n, input logic [31:0] d);
    i_host.scan(1'b0, n, d, r);
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, runs finish in about 5750 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    id = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    mix = '{BP_4PROG, BP_3P1D, BP_2P2D, BP_2P_PRANGE, BP_2P_DRANGE};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    dr(32, 32'h0);
    check(r, id);
    check(tdo_oe, 1'b0);
    ir(OP_BYPASS);
    check(r[3:0], IR_CAPTURE);
    dr(32, 32'h8421f0c3);
    check(r, 32'h8421f0c3 << 1);
    i_host.walk(8'h01, 3);
    i_host.walk(8'h1f, 5);
    dr(32, 32'h0);
    check(r, id);
    $display("test ids done");
    ir(OP_DEV_RESET);
    dr(1, 32'h1);
    check(device_reset, 1'b1);
    check(pin_oe, 8'h00);
    dr(1, 32'h0);
    check(device_reset, 1'b0);
    reset_pin_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    check(device_reset, 1'b1);
    reset_pin_n <= 1'b1;
    ir(OP_SAMPLE);
    dr(24, {8'hf0, 8'h99, 8'h00});
    check(r[7:0], pin_in);
    check({pin_oe, pin_out}, {core_oe, core_out});
    ir(OP_EXTEST);
    check({pin_oe, pin_out}, 16'hf099);
    core_out <= 8'hc3;
    ir(OP_BYPASS);
    check(pin_out, core_out);
    $display("test boundary done");
    ir(OP_DBG_ZERO);
    lock_bit_one <= 1'b1;
    dr(16, 32'h0200);
    check(io_sel, 1'b0);
    check(mbox_rdata, io_rdata);
    lock_bit_one <= 1'b0;
    dr(16, 32'h0200);
    check(io_sel, 1'b1);
    mbox_wr <= 1'b1;
    mbox_wdata <= 8'h35;
    @(posedge core_clk);
    mbox_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(mbox_rdata, 8'hb5);
    ir(OP_DBG_TWO);
    dr(16, 32'h0200);
    check(r[8:0], 9'h135);
    ir(OP_DBG_ZERO);
    dr(16, 32'h0600);
    check(r[8], 1'b1);
    dr(16, 32'h0200);
    check(r[8], 1'b0);
    check(mbox_rdata, 8'h35);
    debug_enable_fuse <= 1'b0;
    dr(16, 32'h0200);
    check(io_sel, 1'b0);
    debug_enable_fuse <= 1'b1;
    for (int m = 0; m < 5; m++) begin
      dr(16, {16'h0, 2'b11, mix[m], 11'h200});
      check(break_cfg, mix[m]);
    end
    dr(16, {16'h0, 2'b11, 3'h7, 11'h200});
    check(break_cfg, BP_2P_DRANGE);
    check({break_step, break_flow}, 2'b11);
    ir(OP_DBG_ONE);
    dr(16, 32'h1234);
    check(r[15:0], cpu_result);
    check(cpu_instr, 16'h1234);
    ir(OP_DBG_THREE);
    dr(18, 32'h2abcd);
    check({bp_sel, bp_addr}, 18'h2abcd);
    $display("test debug done");
    lock_bit_two <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(debug_fuse_prog_ok, 1'b0);
    chip_erase_done <= 1'b1;
    @(posedge core_clk);
    chip_erase_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(debug_fuse_prog_ok, 1'b1);
    lock_bit_two <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      ir(OP_BYPASS);
      port_disable_bit <= !k[0];
      port_enable_fuse <= !k[0];
      ir(OP_SAMPLE);
      port_disable_bit <= 1'b0;
      port_enable_fuse <= 1'b1;
      dr(32, 32'h0);
      check(r, id);
    end
    $display("test locks done");
    summarize();
  end
endmodule
